// File: cst_pkg.sv
package cst_pkg;

    // ==========================================================
    // register offsets (byte addresses: indices times four)
    // ==========================================================
    localparam logic [7:0]  CST_IDX_STATUS    = 8'h6A;
    localparam logic [7:0]  CST_IDX_PIN_SETUP = 8'h6B;
    localparam logic [7:0]  CST_IDX_SOFT_TRIG = 8'h6C;
    localparam logic [11:0] CST_ADDR_STATUS    = {2'h0, CST_IDX_STATUS, 2'h0};
    localparam logic [11:0] CST_ADDR_PIN_SETUP = {2'h0, CST_IDX_PIN_SETUP, 2'h0};
    localparam logic [11:0] CST_ADDR_SOFT_TRIG = {2'h0, CST_IDX_SOFT_TRIG, 2'h0};
    // own register holding the engine-side control bits
    localparam logic [11:0] CST_ADDR_LP_CTRL   = 12'h1B8;

    // ==========================================================
    // field positions
    // ==========================================================
    localparam int CST_POS_FOREGROUND_FINISHED_FLAG  = 0;
    localparam int CST_POS_STOPPED  = 1;
    localparam int CST_POS_CODE_LO  = 2;
    localparam int CST_POS_SEL_LO   = 1;
    localparam int CST_POS_TRIG_SRC = 0;
    localparam int CST_POS_SOFT     = 0;
    localparam int CST_POS_LOW_POWER_BACKGROUND_ENABLE    = 0;
    localparam int CST_POS_LP_WAKE  = 1;
    localparam int CST_POS_BG_EN    = 2;

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic [1:0] CST_RST_SEL       = 2'h0;
    localparam logic       CST_RST_TRIG_SRC  = 1'h0;
    localparam logic       CST_RST_SOFT      = 1'h1;
    localparam logic [2:0] CST_RST_LP_CTRL   = 3'h0;

    // ==========================================================
    // status pin selection codes
    // ==========================================================
    typedef enum logic [1:0] {
        CST_SEL_FOREGROUND_FINISHED_FLAG = 2'h0,
        CST_SEL_STOPPED = 2'h1,
        CST_SEL_ALARM   = 2'h2,
        CST_SEL_LOW     = 2'h3
    } cst_sel_t;

    // engine event group handed in from the calibration engine
    typedef struct packed {
        logic       fg_finished;
        logic       bg_halted;
        logic       bg_resumed;
        logic       alarm;
        logic [2:0] code;
    } cst_engine_t;

endpackage

// File: cst_sync.sv
`timescale 1ns/1ps

// ==========================================================
// two flip-flop synchroniser for pin levels
// ==========================================================
module cst_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // async level in, synchronised level out
    input  wire logic d,
    output logic      q
);

    logic meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RESET_LEVEL;
            q      <= RESET_LEVEL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// File: cst_top.sv
// Local design decision: the APB register port.
`timescale 1ns/1ps

module cst_top
    import cst_pkg::*;
(
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RESETN,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // calibration engine events, same clock
    input  wire cst_engine_t ENGINE,
    // pins
    input  wire logic        TRIGGER_INPUT_PIN,
    output logic             STATUS_OUTPUT_PIN,
    // towards the calibration engine
    output logic             CAL_TRIGGER,
    output logic             CORE_WAKE,
    output logic             LOW_POWER_BACKGROUND_ENABLE,
    output logic             LOW_POWER_WAKE_ON_TRIGGER
);

    // ==========================================================
    // helpers
    // ==========================================================
    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ref_a);
        return a == ref_a;
    endfunction

    // ==========================================================
    // state
    // ==========================================================
    logic       foreground_finished_flag_q;
    logic       stopped_q;
    logic       stopped_d;
    logic [2:0] code_q;
    logic [1:0] sel_q;
    logic       trig_src_q;
    logic       soft_trig_q;
    logic       low_power_background_enable_q;
    logic       lp_wake_q;
    logic       bg_en_q;
    logic       pin_sync;
    logic       trig_sel;
    logic       pin_sel_val;
    logic       wr_access;
    logic       rd_access;
    logic       wr_low;
    logic       mapped;
    logic [31:0] rd_val;

    // trigger pin comes from outside, so it is synchronised first
    cst_sync #(
        .RESET_LEVEL (1'b1)
    ) u_trig_sync (
        .clk   (SYS_CLK),
        .rst_n (RESETN),
        .d     (TRIGGER_INPUT_PIN),
        .q     (pin_sync)
    );

    // ==========================================================
    // apb decode
    // ==========================================================
    // zero wait state: the access phase completes in its first cycle
    assign wr_access = PSEL && PENABLE && PWRITE;
    assign rd_access = PSEL && !PENABLE && !PWRITE;
    assign wr_low    = PSTRB[0];
    assign mapped    = addr_hit(PADDR, CST_ADDR_STATUS)
                    || addr_hit(PADDR, CST_ADDR_PIN_SETUP)
                    || addr_hit(PADDR, CST_ADDR_SOFT_TRIG)
                    || addr_hit(PADDR, CST_ADDR_LP_CTRL);

    // ==========================================================
    // calibration status flags
    // ==========================================================
    // foreground done holds until the engine restarts; the engine owns it
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            foreground_finished_flag_q <= 1'b0;
        end else if (ENGINE.fg_finished) begin
            foreground_finished_flag_q <= 1'b1;
        end else if (ENGINE.bg_resumed && !bg_en_q) begin
            foreground_finished_flag_q <= 1'b0;
        end
    end

    // a halt (background on) or foreground finish (background off) in the same cycle as a resume wins, so no stop is lost
    always_comb begin
        stopped_d = stopped_q;
        if (ENGINE.bg_resumed) begin
            stopped_d = 1'b0;
        end
        if (bg_en_q && ENGINE.bg_halted) begin
            stopped_d = 1'b1;
        end
        if (!bg_en_q && ENGINE.fg_finished) begin
            stopped_d = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            stopped_q <= 1'b0;
        end else begin
            stopped_q <= stopped_d;
        end
    end

    // status code is sampled so reads see a stable value
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            code_q <= 3'h0;
        end else begin
            code_q <= ENGINE.code;
        end
    end

    // ==========================================================
    // software registers
    // ==========================================================
    // pin setup: only the select field and source bit are stored
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sel_q      <= CST_RST_SEL;
            trig_src_q <= CST_RST_TRIG_SRC;
        end else if (wr_access && wr_low && addr_hit(PADDR, CST_ADDR_PIN_SETUP)) begin
            sel_q      <= PWDATA[CST_POS_SEL_LO +: 2];
            trig_src_q <= PWDATA[CST_POS_TRIG_SRC];
        end
    end

    // software trigger resets high so an idle part never sees a trigger
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            soft_trig_q <= CST_RST_SOFT;
        end else if (wr_access && wr_low && addr_hit(PADDR, CST_ADDR_SOFT_TRIG)) begin
            soft_trig_q <= PWDATA[CST_POS_SOFT];
        end
    end

    // low-power and background enables steering the engine
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            {bg_en_q, lp_wake_q, low_power_background_enable_q} <= CST_RST_LP_CTRL;
        end else if (wr_access && wr_low && addr_hit(PADDR, CST_ADDR_LP_CTRL)) begin
            low_power_background_enable_q   <= PWDATA[CST_POS_LOW_POWER_BACKGROUND_ENABLE];
            lp_wake_q <= PWDATA[CST_POS_LP_WAKE];
            bg_en_q   <= PWDATA[CST_POS_BG_EN];
        end
    end

    // ==========================================================
    // read mux
    // ==========================================================
    // status writes fall through here with no effect
    always_comb begin
        rd_val = 32'h0000_0000;
        if (addr_hit(PADDR, CST_ADDR_STATUS)) begin
            rd_val[CST_POS_FOREGROUND_FINISHED_FLAG]      = foreground_finished_flag_q;
            rd_val[CST_POS_STOPPED]      = stopped_q;
            rd_val[CST_POS_CODE_LO +: 3] = code_q;
        end else if (addr_hit(PADDR, CST_ADDR_PIN_SETUP)) begin
            rd_val[CST_POS_SEL_LO +: 2]  = sel_q;
            rd_val[CST_POS_TRIG_SRC]     = trig_src_q;
        end else if (addr_hit(PADDR, CST_ADDR_SOFT_TRIG)) begin
            rd_val[CST_POS_SOFT]         = soft_trig_q;
        end else if (addr_hit(PADDR, CST_ADDR_LP_CTRL)) begin
            rd_val[CST_POS_LOW_POWER_BACKGROUND_ENABLE]        = low_power_background_enable_q;
            rd_val[CST_POS_LP_WAKE]      = lp_wake_q;
            rd_val[CST_POS_BG_EN]        = bg_en_q;
        end
    end

    // data is captured in setup so it stands through the access phase
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            PRDATA <= 32'h0000_0000;
        end else if (rd_access) begin
            PRDATA <= rd_val;
        end
    end

    // ready high through every access; unmapped addresses raise an error
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            PREADY  <= 1'b1;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= 1'b1;
            PSLVERR <= PSEL && !PENABLE && !mapped;
        end
    end

    // ==========================================================
    // trigger selection and pins
    // ==========================================================
    // the unselected source is fully ignored, not merely masked later
    always_comb begin
        if (trig_src_q) begin
            trig_sel = pin_sync;
        end else begin
            trig_sel = soft_trig_q;
        end
    end

    always_comb begin
        unique case (cst_sel_t'(sel_q))
            CST_SEL_FOREGROUND_FINISHED_FLAG: pin_sel_val = foreground_finished_flag_q;
            CST_SEL_STOPPED: pin_sel_val = stopped_q;
            CST_SEL_ALARM:   pin_sel_val = ENGINE.alarm;
            CST_SEL_LOW:     pin_sel_val = 1'b0;
        endcase
    end

    // outputs registered, one cycle behind their sources
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            STATUS_OUTPUT_PIN <= 1'b0;
            CAL_TRIGGER       <= 1'b1;
        end else begin
            STATUS_OUTPUT_PIN <= pin_sel_val;
            CAL_TRIGGER       <= trig_sel;
        end
    end

    // in triggered low-power mode cores only wake on a low trigger;
    // the default high software bit keeps them asleep
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            CORE_WAKE <= 1'b0;
        end else begin
            CORE_WAKE <= low_power_background_enable_q && bg_en_q && lp_wake_q && !trig_sel;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            LOW_POWER_BACKGROUND_ENABLE <= 1'b0;
            LOW_POWER_WAKE_ON_TRIGGER   <= 1'b0;
        end else begin
            LOW_POWER_BACKGROUND_ENABLE <= low_power_background_enable_q && bg_en_q;
            LOW_POWER_WAKE_ON_TRIGGER   <= lp_wake_q;
        end
    end

endmodule

// File: cst_top_asserts.sv
`timescale 1ns/1ps

// ==========================================================
// port checker for the status and trigger block
// ==========================================================
module cst_top_asserts
    import cst_pkg::*;
(
    // clock and reset
    input wire logic        SYS_CLK,
    input wire logic        RESETN,
    // apb
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0]  PSTRB,
    input wire logic [31:0] PRDATA,
    // engine and pins
    input wire cst_engine_t ENGINE,
    input wire logic        TRIGGER_INPUT_PIN,
    input wire logic        STATUS_OUTPUT_PIN,
    input wire logic        CAL_TRIGGER,
    input wire logic        CORE_WAKE
);
    logic [1:0]  sel_q;
    logic        src_q;
    logic        soft_q;
    logic [2:0]  lp_q;
    logic        set_c;
    logic [31:0] rd_mask;

    // shadow of the writable fields, so pin checks know the selection
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sel_q <= CST_RST_SEL;
            src_q <= CST_RST_TRIG_SRC;
            soft_q <= CST_RST_SOFT;
            lp_q <= CST_RST_LP_CTRL;
        end else if (PSEL && PENABLE && PWRITE && PSTRB[0]) begin
            if (PADDR == CST_ADDR_PIN_SETUP) begin
                sel_q <= PWDATA[2:1];
                src_q <= PWDATA[0];
            end
            if (PADDR == CST_ADDR_SOFT_TRIG) soft_q <= PWDATA[0];
            if (PADDR == CST_ADDR_LP_CTRL) lp_q <= PWDATA[2:0];
        end
    end
    // the stopped flag sets from a different event once background is on
    assign set_c = lp_q[CST_POS_BG_EN] ? ENGINE.bg_halted : ENGINE.fg_finished;
    // bits that must read zero; unmapped places read zero throughout
    always_comb begin
        case (PADDR)
            CST_ADDR_STATUS:    rd_mask = 32'hFFFFFFE0;
            CST_ADDR_PIN_SETUP: rd_mask = 32'hFFFFFFF8;
            CST_ADDR_SOFT_TRIG: rd_mask = 32'hFFFFFFFE;
            CST_ADDR_LP_CTRL:   rd_mask = 32'hFFFFFFF8;
            default:            rd_mask = 32'hFFFFFFFF;
        endcase
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    sequence done_s;
        ENGINE.fg_finished && !ENGINE.bg_resumed ##1 sel_q == CST_SEL_FOREGROUND_FINISHED_FLAG;
    endsequence
    sequence stop_s;
        set_c ##1 sel_q == CST_SEL_STOPPED;
    endsequence
    sequence resume_s;
        ENGINE.bg_resumed && !set_c ##1 sel_q == CST_SEL_STOPPED;
    endsequence

    trig_soft_a: assert property (!$past(src_q) |-> CAL_TRIGGER == $past(soft_q))
        else $error("trigger not from software bit");
    trig_pin_a: assert property ($past(src_q) && $past(RESETN, 3) && $past(RESETN, 2)
        |-> CAL_TRIGGER == $past(TRIGGER_INPUT_PIN, 3))
        else $error("trigger not from pin");
    pin_low_a: assert property ($past(sel_q) == CST_SEL_LOW |-> !STATUS_OUTPUT_PIN)
        else $error("status pin not low");
    pin_alarm_a: assert property ($past(sel_q) == CST_SEL_ALARM
        && $past(ENGINE.alarm) == $past(ENGINE.alarm, 2)
        |-> STATUS_OUTPUT_PIN == $past(ENGINE.alarm))
        else $error("status pin not alarm");
    pin_done_a: assert property (done_s |=> STATUS_OUTPUT_PIN)
        else $error("done not on status pin");
    pin_stop_a: assert property (stop_s |=> STATUS_OUTPUT_PIN)
        else $error("stopped not on status pin");
    pin_resume_a: assert property (resume_s |=> !STATUS_OUTPUT_PIN)
        else $error("stopped not cleared");
    core_wake_a: assert property ($past(lp_q) == 3'h7 && CAL_TRIGGER == $past(CAL_TRIGGER)
        |-> CORE_WAKE == !CAL_TRIGGER)
        else $error("core wake wrong");
    rd_zero_a: assert property (PSEL && PENABLE && !PWRITE |-> (PRDATA & rd_mask) == 32'h0)
        else $error("reserved bits not zero");
endmodule

bind cst_top cst_top_asserts u_asserts (.SYS_CLK, .RESETN, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PSTRB, .PRDATA, .ENGINE, .TRIGGER_INPUT_PIN, .STATUS_OUTPUT_PIN,
    .CAL_TRIGGER, .CORE_WAKE);

// File: cst_ctrl_model.sv
`timescale 1ns/1ps

// ==========================================================
// system controller: drives the trigger pin, watches status
// ==========================================================
module cst_ctrl_model (
    // clock
    input wire logic  clk,
    // requested pin level and pace
    input wire logic  trig_req,
    input wire logic  slow,
    // device pins
    input wire logic  status_pin,
    output logic      trig_pin,
    output logic [7:0] status_rises
);
    logic [3:0] dly_q;
    logic       stat_q;

    initial begin
        dly_q = 4'h0;
        stat_q = 1'b0;
        trig_pin = 1'b0;
        status_rises = 8'h00;
    end
    // a slow controller lets its request ripple through four stages
    always @(posedge clk) begin
        dly_q <= {dly_q[2:0], trig_req};
        trig_pin <= slow ? dly_q[3] : trig_req;
        stat_q <= status_pin;
        if (status_pin && !stat_q) status_rises <= status_rises + 8'h01;
    end
endmodule

// File: calibration_status_trigger_test.sv
`timescale 1ns/1ps

module calibration_status_trigger_test
    import cst_pkg::*;
;
    // row: register, value written, value read back, error expected
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdat;
        logic [7:0]  rdat;
        logic        err;
    } cst_row_t;

    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, strb;
    logic        trig_req, slow, trig_pin, stat_pin, cal_trig, core_wake, lp_bg, lp_wake;
    logic [7:0]  rises;
    cst_engine_t eng;
    cst_row_t    rows [6];
    int          num_errors, num_checks;

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    cst_top u_dut (.SYS_CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .ENGINE(eng), .TRIGGER_INPUT_PIN(trig_pin),
        .STATUS_OUTPUT_PIN(stat_pin), .CAL_TRIGGER(cal_trig), .CORE_WAKE(core_wake),
        .LOW_POWER_BACKGROUND_ENABLE(lp_bg), .LOW_POWER_WAKE_ON_TRIGGER(lp_wake));
    cst_ctrl_model u_ctrl (.clk(clk), .trig_req(trig_req), .slow(slow),
        .status_pin(stat_pin), .trig_pin(trig_pin), .status_rises(rises));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; the wait for pready is bounded
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= strb;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) chk(1'b0, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one-cycle engine event: bit 0 foreground, 1 halted, 2 resumed
    task automatic pulse(input logic [2:0] m);
        @(posedge clk);
        eng.fg_finished <= m[0];
        eng.bg_halted <= m[1];
        eng.bg_resumed <= m[2];
        @(posedge clk);
        eng.fg_finished <= 1'b0;
        eng.bg_halted <= 1'b0;
        eng.bg_resumed <= 1'b0;
        tick(3);
    endtask
    task automatic end_sim;
        if (num_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, trig_req, slow} = '0;
        pstrb = 4'hF;
        strb = 4'hF;
        eng = '0;
        rows = '{'{CST_ADDR_PIN_SETUP, 8'hFF, 8'h07, 1'b0}, '{CST_ADDR_PIN_SETUP, 8'h00, 8'h00, 1'b0},
            '{CST_ADDR_SOFT_TRIG, 8'hFE, 8'h00, 1'b0}, '{CST_ADDR_SOFT_TRIG, 8'h01, 8'h01, 1'b0},
            '{CST_ADDR_STATUS, 8'hFF, 8'h00, 1'b0}, '{12'h1B4, 8'hFF, 8'h00, 1'b1}};
        tick(20);
        rst_n <= 1'b1;
        chk(cal_trig, 1'b1);
        apb(CST_ADDR_SOFT_TRIG, 1'b0, 32'h0);
        chk(rd, 32'h1);
        foreach (rows[i]) begin
            apb(rows[i].addr, 1'b1, {24'h0, rows[i].wdat});
            apb(rows[i].addr, 1'b0, 32'h0);
            chk(rd, {24'h0, rows[i].rdat});
            chk(err, rows[i].err);
        end
        // lane 0 strobe low: write dropped
        strb = 4'h0;
        apb(CST_ADDR_SOFT_TRIG, 1'b1, 32'h0);
        strb = 4'hF;
        apb(CST_ADDR_SOFT_TRIG, 1'b0, 32'h0);
        chk(rd, 32'h1);
        // trigger source: slow controller, software bit first, then the selected pin
        slow <= 1'b1;
        tick(10);
        chk(cal_trig, 1'b1);
        apb(CST_ADDR_SOFT_TRIG, 1'b1, 32'h0);
        tick(4);
        chk(cal_trig, 1'b0);
        trig_req <= 1'b1;
        apb(CST_ADDR_PIN_SETUP, 1'b1, 32'h1);
        tick(10);
        chk(cal_trig, 1'b1);
        trig_req <= 1'b0;
        tick(10);
        chk(cal_trig, 1'b0);
        apb(CST_ADDR_PIN_SETUP, 1'b1, 32'h0);
        apb(CST_ADDR_SOFT_TRIG, 1'b1, 32'h1);
        tick(4);
        chk(cal_trig, 1'b1);
        // status flags and pin selection, background off
        pulse(3'b001);
        chk(stat_pin, 1'b1);
        apb(CST_ADDR_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h3);
        apb(CST_ADDR_PIN_SETUP, 1'b1, 32'h2);
        tick(3);
        chk(stat_pin, 1'b1);
        pulse(3'b100);
        chk(stat_pin, 1'b0);
        eng.alarm <= 1'b1;
        apb(CST_ADDR_PIN_SETUP, 1'b1, 32'h4);
        tick(3);
        chk(stat_pin, 1'b1);
        apb(CST_ADDR_PIN_SETUP, 1'b1, 32'h6);
        tick(3);
        chk(stat_pin, 1'b0);
        eng.alarm <= 1'b0;
        eng.code <= 3'h5;
        // background on: halt sets, halt with resume keeps it set
        apb(CST_ADDR_LP_CTRL, 1'b1, 32'h4);
        apb(CST_ADDR_PIN_SETUP, 1'b1, 32'h2);
        pulse(3'b010);
        chk(stat_pin, 1'b1);
        pulse(3'b110);
        chk(stat_pin, 1'b1);
        apb(CST_ADDR_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h16);
        chk(rises, 8'h03);
        // triggered low power: wake only while the trigger is low
        apb(CST_ADDR_LP_CTRL, 1'b1, 32'h7);
        tick(4);
        chk({lp_bg, lp_wake, core_wake}, 3'b110);
        apb(CST_ADDR_SOFT_TRIG, 1'b1, 32'h0);
        tick(4);
        chk(core_wake, 1'b1);
        end_sim();
    end

    // watchdog well beyond the fewer than two hundred cycles the run needs
    initial begin
        #20000;
        num_errors++;
        end_sim();
    end
endmodule
